// ---- common/pwm_autoreload_timer_defs.vh ----
// Purpose: Constants for the 8-bit auto-reload PWM timer.
// Assumes: Register byte address is four times the register index.
// Notes: Indices keep the printed offsets; data sits in bits 7:0.
`ifndef PWM_AUTORELOAD_TIMER_DEFS_VH
`define PWM_AUTORELOAD_TIMER_DEFS_VH
`define IDX_DUTY3 8'h31
`define IDX_DUTY2 8'h32
`define IDX_DUTY1 8'h33
`define IDX_DUTY0 8'h34
`define IDX_OUTCTL 8'h35
`define IDX_CSR 8'h36
`define IDX_CNT 8'h37
`define IDX_RELOAD 8'h38
`define IDX_CAPCSR 8'h39
`define IDX_CAP1 8'h3a
`define IDX_CAP2 8'h3b
`define CSR_EXT_CLOCK_SELECT 7
`define CSR_CC_HI 6
`define CSR_CC_LO 4
`define CSR_RUN 3
`define CSR_FORCE 2
`define CSR_OIE 1
`define CSR_OVF 0
`define OUT_EN_HI 7
`define OUT_EN_LO 4
`define OUT_POL_HI 3
`define OUT_POL_LO 0
`define CAP_EDGE_HI 5
`define CAP_EDGE_LO 4
`define CAP_IE_HI 3
`define CAP_IE_LO 2
`define CNT_MAX 8'hff
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define REG_RESET 8'h00
`define PSC_MAX_MASK 7'h7f
`endif

// ---- dv/pwm_autoreload_timer_chk.sv ----
// Purpose: Port-level checks of the auto-reload PWM timer.
// Assumes: Only the top module's ports are visible.
// Notes: Attached by bind with by-name connections.
`timescale 1ns/100ps
module pwm_autoreload_timer_chk
(
  input wire i_clk,
  input wire i_srst,
  input wire i_awvalid,
  input wire o_awready,
  input wire i_wvalid,
  input wire o_wready,
  input wire o_bvalid,
  input wire [11:0] i_araddr,
  input wire i_arvalid,
  input wire o_arready,
  input wire [31:0] o_rdata,
  input wire [1:0] o_rresp,
  input wire o_rvalid,
  input wire [3:0] o_pwm_out_pin,
  input wire [3:0] o_pwm_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  wire ar_hs = i_arvalid && o_arready;
  wire [9:0] ar_idx = i_araddr[11:2];
  a_read_answer: assert property (ar_hs |=> o_rvalid && !o_arready)
    else $error("read answer missing");
  a_write_answer: assert property (i_awvalid && o_awready && i_wvalid
    && o_wready |=> !o_awready ##1 o_bvalid) else $error("no write answer");
  a_write_busy: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write taken while busy");
  a_read_busy: assert property (o_rvalid |-> !o_arready)
    else $error("read taken while busy");
  a_rdata_upper: assert property (o_rvalid |-> o_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_unmapped_read: assert property (ar_hs && (ar_idx < 10'h31 ||
    ar_idx > 10'h3b) |=> o_rresp == 2'b10 && o_rdata == 32'h0)
    else $error("unmapped read answered wrongly");
  a_force_reads0: assert property (ar_hs && ar_idx == 10'h36 |=>
    !o_rdata[2]) else $error("force bit read back");
  a_capcsr_rsvd: assert property (ar_hs && ar_idx == 10'h39 |=>
    o_rdata[7:6] == 2'b00) else $error("reserved bits set");
  a_pwm_gated: assert property ((o_pwm_out_pin & ~o_pwm_oe &
    ~$past(o_pwm_oe)) == 4'h0) else $error("disabled pin driven");
endmodule
bind pwm_autoreload_timer pwm_autoreload_timer_chk u_chk (.*);

// ---- dv/pwm_pin_partner.sv ----
// Purpose: Pin-side model driving capture inputs and the count input.
// Assumes: Levels requested by the bench change at a clock edge.
// Notes: Pins change only after a register stage, like a board driver.
`timescale 1ns/100ps
module pwm_pin_partner
(
  input wire i_clk,
  input wire [1:0] i_cap_lvl,
  input wire i_ext_lvl,
  output reg [1:0] o_capture_in_pin,
  output reg o_ext_clk
);
  initial o_capture_in_pin = 2'b00;
  initial o_ext_clk = 1'b0;
  always @(posedge i_clk)
  begin
    o_capture_in_pin <= i_cap_lvl;
    o_ext_clk <= i_ext_lvl;
  end
endmodule

// ---- dv/tb_pwm_autoreload_timer.sv ----
// Purpose: Self-checking bench of the auto-reload PWM timer.
// Assumes: AXI4-Lite master tasks, byte address four times the index.
// Notes: Random register data from a fixed seed.
`timescale 1ns/100ps
`include "pwm_autoreload_timer_defs.vh"
module tb_pwm_autoreload_timer;
  reg i_clk = 0, i_srst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  reg ext = 0;
  reg [11:0] awa = 0, ara = 0;
  reg [31:0] wd = 0, rd;
  reg [1:0] cap = 0;
  reg [7:0] v, k;
  wire awr, wrd, bv, arr, rv, ovi, ecl;
  wire [1:0] cpi, cirq, brs;
  wire [31:0] rdt;
  wire [3:0] pin;
  integer n_mismatch = 0, comparisons = 0, cyc = 0, n;
  initial forever #5 i_clk = ~i_clk;
  pwm_autoreload_timer u_dut (.i_clk(i_clk), .i_srst(i_srst),
    .i_awaddr(awa), .i_awprot(3'h0), .i_awvalid(awv), .o_awready(awr),
    .i_wdata(wd), .i_wstrb(4'h1), .i_wvalid(wv), .o_wready(wrd),
    .o_bresp(brs), .o_bvalid(bv), .i_bready(bry), .i_araddr(ara),
    .i_arprot(3'h0), .i_arvalid(arv), .o_arready(arr), .o_rdata(rdt),
    .o_rresp(), .o_rvalid(rv), .i_rready(rry), .i_ext_clk(ecl),
    .i_capture_in_pin(cpi), .o_pwm_out_pin(pin), .o_pwm_oe(),
    .o_ovf_irq(ovi), .o_cap_irq(cirq));
  pwm_pin_partner u_pins (.i_clk(i_clk), .i_cap_lvl(cap),
    .i_ext_lvl(ext), .o_capture_in_pin(cpi), .o_ext_clk(ecl));
  function [7:0] high_counts(input [7:0] rl, input [7:0] dc);
    high_counts = dc - rl + 8'h01;
  endfunction
  task ck(input [31:0] s, input [31:0] e);
  begin
    comparisons = comparisons + 1;
    if (s !== e)
    begin
      n_mismatch = n_mismatch + 1;
      $display("mismatch t=%0t got %h exp %h", $time, s, e);
    end
  end
  endtask
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(posedge i_clk);
    awa <= {2'b00, a, 2'b00};
    wd <= {24'h0, d};
    awv <= 1;
    wv <= 1;
    bry <= 1;
    do
    begin
      @(posedge i_clk);
      if (awr) awv <= 0;
      if (wrd) wv <= 0;
    end
    while (bv !== 1'b1);
    bry <= 0;
    ck(brs, 2'b00);
  end
  endtask
  task rck(input [7:0] a, input [31:0] e);
  begin
    @(posedge i_clk);
    ara <= {2'b00, a, 2'b00};
    arv <= 1;
    rry <= 1;
    do
    begin
      @(posedge i_clk);
      if (arr) arv <= 0;
    end
    while (rv !== 1'b1);
    rd = rdt;
    rry <= 0;
    ck(rd, e);
  end
  endtask
  task tally_and_finish;
  begin
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 10000)
    begin
      n_mismatch = n_mismatch + 1;
      tally_and_finish;
    end
  end
  initial
  begin
    v = $urandom(66171);
    repeat (10) @(posedge i_clk);
    i_srst <= 0;
    for (k = 8'h31; k <= 8'h3b; k = k + 1)
      rck(k, 0);
    rck(8'h20, 0);
    $display("test reset values done");
    for (k = 8'h31; k <= 8'h34; k = k + 1)
    begin
      v = $urandom;
      wr(k, v);
      rck(k, v);
    end
    wr(`IDX_CAP1, 8'ha5);
    rck(`IDX_CAP1, 0);
    v = $urandom;
    wr(`IDX_CNT, v);
    repeat (20) @(posedge i_clk);
    rck(`IDX_CNT, v);
    $display("test register access done");
    wr(`IDX_CAPCSR, 8'h14);
    @(posedge i_clk);
    cap <= 2'b11;
    repeat (8) @(posedge i_clk);
    ck(cirq, 2'b01);
    rck(`IDX_CAPCSR, 8'h15);
    rck(`IDX_CAP1, v);
    repeat (2) @(posedge i_clk);
    ck(cirq, 2'b00);
    cap <= 2'b00;
    repeat (8) @(posedge i_clk);
    rck(`IDX_CAPCSR, 8'h16);
    ck(cirq, 2'b00);
    rck(`IDX_CAP2, v);
    $display("test capture done");
    wr(`IDX_RELOAD, 8'hf0);
    wr(`IDX_CSR, 8'h7e);
    rck(`IDX_CNT, 8'hf0);
    repeat (2100) @(posedge i_clk);
    ck(ovi, 1'b1);
    rck(`IDX_CSR, 8'h7b);
    rck(`IDX_CSR, 8'h7a);
    ck(ovi, 1'b0);
    rck(`IDX_CNT, 8'hf0);
    $display("test overflow done");
    wr(`IDX_DUTY2, 8'hf7);
    wr(`IDX_DUTY1, 8'h00);
    wr(`IDX_DUTY0, 8'hff);
    wr(`IDX_CSR, 8'h0c);
    wr(`IDX_OUTCTL, 8'h70);
    repeat (40) @(posedge i_clk);
    ck(pin[1:0], 2'b01);
    n = 0;
    repeat (32)
    begin
      @(posedge i_clk);
      n = n + pin[2];
    end
    ck(n, 2 * high_counts(8'hf0, 8'hf7));
    wr(`IDX_OUTCTL, 8'h33);
    repeat (3) @(posedge i_clk);
    ck(pin, 4'b0010);
    wr(`IDX_OUTCTL, 8'h03);
    repeat (3) @(posedge i_clk);
    ck(pin, 4'b0000);
    $display("test pwm done");
    wr(`IDX_CSR, 8'h88);
    wr(`IDX_CNT, 8'h40);
    repeat (3)
    begin
      repeat (4) @(posedge i_clk);
      ext <= 1;
      repeat (4) @(posedge i_clk);
      ext <= 0;
    end
    repeat (6) @(posedge i_clk);
    rck(`IDX_CNT, 8'h43);
    $display("test external count done");
    tally_and_finish;
  end
endmodule

// ---- verilog/pwm_autoreload_timer.v ----
// Purpose: 8-bit auto-reload timer, four PWM outputs, two input captures.
// Assumes: AXI4-Lite slave, 12-bit byte address, one access of each kind.
// Notes: Read side effects act in the cycle the read address is taken.
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "pwm_autoreload_timer_defs.vh"
module pwm_autoreload_timer
(
  input wire i_clk,
  input wire i_srst,
  input wire [11:0] i_awaddr,
  input wire [2:0] i_awprot,
  input wire i_awvalid,
  output reg o_awready,
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  input wire i_wvalid,
  output reg o_wready,
  output reg [1:0] o_bresp,
  output reg o_bvalid,
  input wire i_bready,
  input wire [11:0] i_araddr,
  input wire [2:0] i_arprot,
  input wire i_arvalid,
  output reg o_arready,
  output reg [31:0] o_rdata,
  output reg [1:0] o_rresp,
  output reg o_rvalid,
  input wire i_rready,
  input wire i_ext_clk,
  input wire [1:0] i_capture_in_pin,
  output reg [3:0] o_pwm_out_pin,
  output reg [3:0] o_pwm_oe,
  output reg o_ovf_irq,
  output reg [1:0] o_cap_irq
);

  // Address decoding is shared by the write path, the read path and the
  // read side effects, so it lives in functions. The word index is the
  // byte address shifted down by two, and the two low address bits are
  // ignored. Any address whose upper bits are not zero is outside the map,
  // even where its index bits would alias a register.
  function hit;
    input [11:0] addr;
    input [7:0] idx;
    begin
      hit = (addr[11:2] == {2'b00, idx});
    end
  endfunction

  function mapped;
    input [11:0] addr;
    begin
      mapped = (addr[11:10] == 2'b00) && (addr[9:2] >= `IDX_DUTY3) &&
        (addr[9:2] <= `IDX_CAP2);
    end
  endfunction

  // A counter tick is due when every prescaler bit below the ratio is one.
  // The prescaler itself counts every input tick while the counter runs, so selecting a new
  // ratio takes effect at once, without waiting for a wrap. A ratio of one
  // gives an empty mask, and every input tick then counts.
  function psc_tick;
    input [6:0] psc;
    input [2:0] sel;
    reg [6:0] mask;
    begin
      mask = ~(`PSC_MAX_MASK << sel);
      psc_tick = ((psc & mask) == mask);
    end
  endfunction

  // Duty registers and their hidden compare shadows first, then the other
  // software-visible state, the synchroniser stages and the latched write beat. The duty registers
  // are indexed by channel number, not by register order.
  reg [7:0] duty [0:3];
  reg [7:0] compare_shadow [0:3];
  reg [3:0] out_en;
  reg [3:0] channel_polarity;
  reg ext_clock_select;
  reg [2:0] prescale_select;
  reg counter_run;
  reg overflow_irq_en;
  reg overflow_flag;
  reg [7:0] counter;
  reg [6:0] prescaler;
  reg [7:0] reload;
  reg [1:0] edge_sel;
  reg [1:0] capture_irq_en;
  reg [1:0] capture_flag;
  reg [7:0] captured_count [0:1];
  reg ext_prev;
  reg [1:0] cap_s1;
  reg [1:0] cap_s2;
  reg [1:0] cap_s3;
  reg [11:0] aw_addr;
  reg [7:0] w_byte;
  reg w_lane0;

  reg wr_do;
  reg wr_cnt;
  reg wr_force;
  reg rd_do;
  reg rd_csr;
  reg [1:0] rd_cap;
  reg in_tick;
  reg cnt_tick;
  reg ovf_evt;
  reg [1:0] cap_evt;
  reg next_ovf;
  reg [1:0] next_cap_flag;
  reg [3:0] next_level;
  reg [7:0] rd_val;
  integer i;
  integer j;

  // The write strobe is high for exactly one cycle, once both the address
  // and the data beat have been taken and before the response is raised.
  // Counter writes and forced reloads both clear the prescaler and take
  // priority over a tick in the same cycle, so an overflow can never be
  // flagged for a count that software has just overwritten.
  // The read mux returns zero for anything outside the map, so that an
  // error response never carries register contents.

  always @*
  begin
    wr_do = ~o_awready & ~o_wready & ~o_bvalid;
    wr_cnt = wr_do & w_lane0 & hit(aw_addr, `IDX_CNT);
    wr_force = wr_do & w_lane0 & hit(aw_addr, `IDX_CSR) &
      w_byte[`CSR_FORCE];
    rd_do = i_arvalid & o_arready;
    rd_csr = rd_do & hit(i_araddr, `IDX_CSR);
    rd_cap[0] = rd_do & hit(i_araddr, `IDX_CAP1);
    rd_cap[1] = rd_do & hit(i_araddr, `IDX_CAP2);
    in_tick = ext_clock_select ? (i_ext_clk & ~ext_prev) : 1'b1;
    cnt_tick = counter_run & in_tick &
      psc_tick(prescaler, prescale_select);
    ovf_evt = cnt_tick & (counter == `CNT_MAX) &
      ~wr_cnt & ~wr_force;
    for (i = 0; i < 2; i = i + 1)
    begin
      // Capture is inhibited until the flag is read away.
      cap_evt[i] = (edge_sel[i] ? (cap_s2[i] & ~cap_s3[i]) :
        (~cap_s2[i] & cap_s3[i])) &
        (~capture_flag[i] | rd_cap[i]);
      next_cap_flag[i] = cap_evt[i] |
        (capture_flag[i] & ~rd_cap[i]);
    end
    next_ovf = ovf_evt | (overflow_flag & ~rd_csr);
    for (i = 0; i < 4; i = i + 1)
    begin
      next_level[i] = (counter <= compare_shadow[i]) ^
        channel_polarity[i];
    end
    case (i_araddr[9:2])
      `IDX_DUTY3: rd_val = duty[3];
      `IDX_DUTY2: rd_val = duty[2];
      `IDX_DUTY1: rd_val = duty[1];
      `IDX_DUTY0: rd_val = duty[0];
      `IDX_OUTCTL: rd_val = {out_en, channel_polarity};
      `IDX_CSR: rd_val = {ext_clock_select, prescale_select, counter_run,
        1'b0, overflow_irq_en, overflow_flag};
      `IDX_CNT: rd_val = counter;
      `IDX_RELOAD: rd_val = reload;
      `IDX_CAPCSR: rd_val = {2'b00, edge_sel, capture_irq_en,
        capture_flag};
      `IDX_CAP1: rd_val = captured_count[0];
      `IDX_CAP2: rd_val = captured_count[1];
      default: rd_val = `REG_RESET;
    endcase
    if (!mapped(i_araddr))
      rd_val = `REG_RESET;
  end

  // Bus slave. Address and data beats are taken independently and held
  // until the response handshake, so the master may offer them in either
  // order. Readies drop after a beat and only return with the response,
  // which keeps at most one write and one read in flight. The read answer
  // is registered at the address handshake, so read side effects on the
  // flags happen in that same cycle.
  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= `RESP_OKAY;
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h00000000;
      o_rresp <= `RESP_OKAY;
      aw_addr <= 12'h000;
      w_byte <= `REG_RESET;
      w_lane0 <= 1'b0;
    end
    else
    begin
      if (i_awvalid & o_awready)
      begin
        aw_addr <= i_awaddr;
        o_awready <= 1'b0;
      end
      if (i_wvalid & o_wready)
      begin
        w_byte <= i_wdata[7:0];
        w_lane0 <= i_wstrb[0];
        o_wready <= 1'b0;
      end
      if (wr_do)
      begin
        o_bvalid <= 1'b1;
        o_bresp <= mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (o_bvalid & i_bready)
      begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
      if (rd_do)
      begin
        o_arready <= 1'b0;
        o_rvalid <= 1'b1;
        o_rdata <= {24'h000000, rd_val};
        o_rresp <= mapped(i_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (o_rvalid & i_rready)
      begin
        o_rvalid <= 1'b0;
        o_arready <= 1'b1;
      end
    end
  end

  // Timer core. Registers, counter, prescaler, capture and the pin
  // outputs all update here, on every clock edge. The capture pins pass
  // through two synchroniser stages, and a third stage gives the edge
  // detector its previous level. Flags take the set over a clear that
  // falls in the same cycle, so no event is lost to a racing read.
  // Pin levels and interrupt lines are registered so that every output
  // comes straight from a flip-flop; this costs one cycle of latency.
  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      for (j = 0; j < 4; j = j + 1)
      begin
        duty[j] <= `REG_RESET;
        compare_shadow[j] <= `REG_RESET;
      end
      out_en <= 4'h0;
      channel_polarity <= 4'h0;
      ext_clock_select <= 1'b0;
      prescale_select <= 3'h0;
      counter_run <= 1'b0;
      overflow_irq_en <= 1'b0;
      overflow_flag <= 1'b0;
      counter <= `REG_RESET;
      prescaler <= 7'h00;
      reload <= `REG_RESET;
      edge_sel <= 2'b00;
      capture_irq_en <= 2'b00;
      capture_flag <= 2'b00;
      captured_count[0] <= `REG_RESET;
      captured_count[1] <= `REG_RESET;
      ext_prev <= 1'b0;
      cap_s1 <= 2'b00;
      cap_s2 <= 2'b00;
      cap_s3 <= 2'b00;
      o_pwm_out_pin <= 4'h0;
      o_pwm_oe <= 4'h0;
      o_ovf_irq <= 1'b0;
      o_cap_irq <= 2'b00;
    end
    else
    begin
      ext_prev <= i_ext_clk;
      cap_s1 <= i_capture_in_pin;
      cap_s2 <= cap_s1;
      cap_s3 <= cap_s2;
      if (wr_do & w_lane0 & mapped(aw_addr))
      begin
        case (aw_addr[9:2])
          `IDX_DUTY3: duty[3] <= w_byte;
          `IDX_DUTY2: duty[2] <= w_byte;
          `IDX_DUTY1: duty[1] <= w_byte;
          `IDX_DUTY0: duty[0] <= w_byte;
          `IDX_OUTCTL:
          begin
            out_en <= w_byte[`OUT_EN_HI:`OUT_EN_LO];
            channel_polarity <= w_byte[`OUT_POL_HI:`OUT_POL_LO];
          end
          `IDX_CSR:
          begin
            ext_clock_select <= w_byte[`CSR_EXT_CLOCK_SELECT];
            prescale_select <= w_byte[`CSR_CC_HI:`CSR_CC_LO];
            counter_run <= w_byte[`CSR_RUN];
            overflow_irq_en <= w_byte[`CSR_OIE];
          end
          `IDX_RELOAD: reload <= w_byte;
          `IDX_CAPCSR:
          begin
            edge_sel <= w_byte[`CAP_EDGE_HI:`CAP_EDGE_LO];
            capture_irq_en <= w_byte[`CAP_IE_HI:`CAP_IE_LO];
          end
          default:
          begin
          end
        endcase
      end
      if (wr_cnt | wr_force)
      begin
        counter <= wr_cnt ? w_byte : reload;
        prescaler <= 7'h00;
      end
      else if (counter_run & in_tick)
      begin
        prescaler <= prescaler + 7'h01;
        if (ovf_evt)
          counter <= reload;
        else if (cnt_tick)
          counter <= counter + 8'h01;
      end
      if (ovf_evt)
      begin
        for (j = 0; j < 4; j = j + 1)
        begin
          compare_shadow[j] <= duty[j];
        end
      end
      overflow_flag <= next_ovf;
      capture_flag <= next_cap_flag;
      // A capture latches the count standing in the cycle the synchronised
      // edge is seen, which is the count after the pin edge.
      for (j = 0; j < 2; j = j + 1)
      begin
        if (cap_evt[j])
          captured_count[j] <= counter;
      end
      // Disabled channels are held low and their enables are mirrored on
      // the output-enable lines, so a pad never shows a stale level.
      o_pwm_out_pin <= next_level & out_en;
      o_pwm_oe <= out_en;
      o_ovf_irq <= overflow_irq_en & next_ovf;
      o_cap_irq <= capture_irq_en & next_cap_flag;
    end
  end

endmodule
